// [shared/dcs_cfg.svh]
// Purpose: constants of the chain/stride sequencer (offsets, fields, resets)
// Assumes: 32-bit AHB-Lite register port, word-aligned registers
// Notes:   definitions only; included by bare name
`ifndef DCS_CFG_SVH
`define DCS_CFG_SVH

// register byte offsets
`define DCS_OFF_CTRL   8'h00
`define DCS_OFF_PSRC   8'h04
`define DCS_OFF_PDST   8'h08
`define DCS_OFF_PLEN   8'h0c
`define DCS_OFF_PLINK  8'h10
`define DCS_OFF_SSRC   8'h14
`define DCS_OFF_SDST   8'h18
`define DCS_OFF_SLEN   8'h1c
`define DCS_OFF_SLINK  8'h20
`define DCS_OFF_STAT   8'h24
`define DCS_OFF_MASK   8'h28
`define DCS_OFF_COUNT  8'h2c

// control register fields
`define DCS_B_RUN      0
`define DCS_B_SVAL     1
`define DCS_B_CHAIN    2
`define DCS_B_CSEL     3
`define DCS_B_SHOLD    4
`define DCS_B_DHOLD    5
`define DCS_F_SSZ_LO   6
`define DCS_F_DSZ_LO   8
`define DCS_B_SSTR     10
`define DCS_B_DSTR     11
`define DCS_F_MUL_LO   12
`define DCS_F_CNT_LO   16
`define DCS_B_BURST    19
`define DCS_B_LOWP     20
// status / mask fields
`define DCS_B_TC       0
`define DCS_B_NULL     1

`define DCS_RST_WORD   32'h0000_0000
`define DCS_NULL_PTR   32'h0000_0000
`define DCS_DESC_LAST  2'h3
`define DCS_ONE32      32'h0000_0001

`endif

// [shared/dcs_pkg.sv]
// Purpose: types of the chain/stride sequencer
// Assumes: constants live in dcs_cfg.svh
// Notes:   nothing here is imported; users write dcs_pkg::name
`default_nettype none
package dcs_pkg;

   // channel sequencing states
   typedef enum logic [2:0] {
      st_idle  = 3'b000,  // channel stopped
      st_fetch = 3'b001,  // reading a descriptor
      st_load  = 3'b010,  // secondary into primary
      st_run   = 3'b011,  // issuing data beats
      st_term  = 3'b100   // terminal count handling
   } dcs_state_e;

   // one data beat handed to the mover
   typedef struct packed {
      logic [31:0] src;   // read address
      logic [31:0] dst;   // write address
      logic [1:0]  ssz;   // source word size code
      logic [1:0]  dsz;   // dest word size code
      logic        burst; // burst mode requested
   } dcs_beat_s;

   // address walker state
   typedef struct packed {
      logic [31:0] set;   // first address of the current set
      logic [31:0] cur;   // address in use
      logic [2:0]  idx;   // steps taken in this set
   } dcs_strd_s;

   // whole sequencer state
   typedef struct packed {
      dcs_state_e  st;
      logic        run, sval, chain, csel, shold, dhold, sson, dson, burst, lowp;
      logic [1:0]  ssz, dsz;
      logic [2:0]  smul, scnt;
      logic [31:0] psrc, pdst, plen, plink, ssrc, sdst, slen, slink, cnt, fptr;
      logic        tcf, nlf, nlm, tc_pulse;
      logic [1:0]  widx;
      logic        aw_v, aw_w;
      logic [7:0]  aw_a;
      logic [31:0] hrdata;
   } dcs_seq_s;

endpackage
`default_nettype wire

// [src/dcs_seq.sv]
// Purpose: one DMA channel sequencer: double buffer, descriptor chain, stride
// Assumes: AHB-Lite register slave; mover takes beats; memory read port
// Notes:   zero-wait slave, response always OKAY
// Overview of operation
// (RULE1) no double buffer: terminal count clears run
// (RULE2) double buffer: run set again after reload
// (RULE3) secondary valid cleared after terminal count
// (RULE4) software edits primary only when stopped, empty
// (RULE5) finish with secondary empty disables channel
// (RULE6) chaining only high priority, never burst
// (RULE7) chaining needs 32-bit sizes, secondary valid
// (RULE8) chain start fetches descriptor, copies, runs
// (RULE9) each terminal count fetches next; null ends
// (RULE10) descriptor fetch reads pointer into secondary set
// (RULE11) descriptor: source, dest, length, next pointer
// (RULE12) chain interrupt every count or final only
// (RULE13) null next pointer latches null-link flag
// (RULE14) chain end clears secondary valid
// (RULE15) separate stride enables for source, destination
// (RULE16) striding requires its address hold cleared
// (RULE17) stride step is multiplier times word size
// (RULE18) count field sets steps per set
// (RULE19) sets start one word after previous set
// (RULE20) burst bit equals low priority bit
// (RULE21) program maximum burst size highest setting
// (RULE22) burst needs incrementing, aligned addresses
// (RULE23) terminal count when byte count reaches length
// (RULE24) reload secondary into primary at terminal count
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`include "dcs_cfg.svh"
`default_nettype none
module dcs_seq (
   input  wire logic             hclk,       // system clock
   input  wire logic             hresetn,    // async reset, low
   input  wire logic             hsel,       // slave select
   input  wire logic [31:0]      haddr,      // byte address
   input  wire logic [1:0]       htrans,     // transfer type
   input  wire logic             hwrite,     // write when high
   input  wire logic [2:0]       hsize,      // word only
   input  wire logic [31:0]      hwdata,     // write data
   input  wire logic             hready,     // bus ready
   output logic      [31:0]      hrdata,     // read data
   output logic                  hreadyout,  // always ready
   output logic                  hresp,      // always OKAY
   output logic                  rd_req,     // descriptor word read
   output logic      [31:0]      rd_addr,    // descriptor word address
   input  wire logic             rd_ack,     // read data valid
   input  wire logic [31:0]      rd_data,    // descriptor word
   output logic                  beat_valid, // beat offered
   output dcs_pkg::dcs_beat_s    beat,       // beat addresses
   input  wire logic             beat_ready, // mover took the beat
   output logic                  tc_event,   // terminal count pulse
   output logic                  null_link_summary // unmasked null-link
);
   dcs_pkg::dcs_seq_s q, d;       // state and next state
   logic              a_phase;    // address phase taken
   logic              ctrl_wr;    // control written this cycle
   logic              ld;         // restart both walkers
   logic [31:0]       ld_src;     // source walker base
   logic [31:0]       ld_dst;     // dest walker base
   logic [31:0]       wsb;        // source word bytes
   logic [31:0]       addr_w [2]; // walker outputs
   logic              beat_hs;    // beat handshake
   logic              final_tc;   // last count of a chain

   assign a_phase   = hsel && htrans[1] && hready;
   assign ctrl_wr   = q.aw_v && q.aw_w && q.aw_a == `DCS_OFF_CTRL;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = q.hrdata;
   assign wsb       = `DCS_ONE32 << q.ssz;
   assign beat_valid = q.st == dcs_pkg::st_run && q.cnt < q.plen; // [RULE23]
   assign beat_hs   = beat_valid && beat_ready;
   assign rd_req    = q.st == dcs_pkg::st_fetch;
   assign rd_addr   = q.fptr + {28'h0, q.widx, 2'b00}; // [RULE11] [RULE10]
   assign final_tc  = q.plink == `DCS_NULL_PTR;
   assign tc_event  = q.tc_pulse;
   assign null_link_summary = q.nlf && !q.nlm; // [RULE13]
   assign beat.src  = addr_w[0];
   assign beat.dst  = addr_w[1];
   assign beat.ssz  = q.ssz;
   assign beat.dsz  = q.dsz;
   assign beat.burst = q.burst;

   ////////////////////////////////////////////////////////////////////////
   // register read view
   function automatic logic [31:0] rd_mux(input dcs_pkg::dcs_seq_s s,
                                          input logic [7:0] a);
      logic [31:0] c;
      c = `DCS_RST_WORD;
      c[`DCS_B_RUN]   = s.run;
      c[`DCS_B_SVAL]  = s.sval;
      c[`DCS_B_CHAIN] = s.chain;
      c[`DCS_B_CSEL]  = s.csel;
      c[`DCS_B_SHOLD] = s.shold;
      c[`DCS_B_DHOLD] = s.dhold;
      c[`DCS_F_SSZ_LO +: 2] = s.ssz;
      c[`DCS_F_DSZ_LO +: 2] = s.dsz;
      c[`DCS_B_SSTR]  = s.sson;
      c[`DCS_B_DSTR]  = s.dson;
      c[`DCS_F_MUL_LO +: 3] = s.smul;
      c[`DCS_F_CNT_LO +: 3] = s.scnt;
      c[`DCS_B_BURST] = s.burst;
      c[`DCS_B_LOWP]  = s.lowp;
      unique case (a)
         `DCS_OFF_CTRL:  rd_mux = c;
         `DCS_OFF_PSRC:  rd_mux = s.psrc;
         `DCS_OFF_PDST:  rd_mux = s.pdst;
         `DCS_OFF_PLEN:  rd_mux = s.plen;
         `DCS_OFF_PLINK: rd_mux = s.plink;
         `DCS_OFF_SSRC:  rd_mux = s.ssrc;
         `DCS_OFF_SDST:  rd_mux = s.sdst;
         `DCS_OFF_SLEN:  rd_mux = s.slen;
         `DCS_OFF_SLINK: rd_mux = s.slink;
         `DCS_OFF_STAT:  rd_mux = {30'h0, s.nlf, s.tcf};
         `DCS_OFF_MASK:  rd_mux = {30'h0, s.nlm, 1'b0};
         `DCS_OFF_COUNT: rd_mux = s.cnt;
         default:        rd_mux = `DCS_RST_WORD; // unmapped reads zero
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // sequencer and register file
   always_comb begin
      d = q;
      d.tc_pulse = 1'b0;
      ld = 1'b0;
      ld_src = q.ssrc;
      ld_dst = q.sdst;
      // software clears of sticky flags come first so a same-cycle set wins
      if (q.aw_v && q.aw_w && q.aw_a == `DCS_OFF_STAT) begin
         if (hwdata[`DCS_B_TC])   d.tcf = 1'b0;
         if (hwdata[`DCS_B_NULL]) d.nlf = 1'b0;
      end
      unique case (q.st)
         dcs_pkg::st_idle: begin
            if (q.run) begin
               if (q.chain) begin
                  if (q.plink == `DCS_NULL_PTR) begin // nothing to fetch [RULE9]
                     d.run  = 1'b0;
                     d.sval = 1'b0;
                  end else begin
                     d.fptr = q.plink; // only the pointer is used [RULE8]
                     d.widx = 2'h0;
                     d.st   = dcs_pkg::st_fetch;
                  end
               end else begin
                  ld = 1'b1;
                  ld_src = q.psrc;
                  ld_dst = q.pdst;
                  d.cnt = `DCS_RST_WORD;
                  d.st  = dcs_pkg::st_run;
               end
            end
         end
         dcs_pkg::st_fetch: begin
            if (rd_ack) begin
               // fetched words land in the secondary set [RULE10] [RULE11]
               unique case (q.widx)
                  2'h0: d.ssrc = rd_data;
                  2'h1: d.sdst = rd_data;
                  2'h2: d.slen = rd_data;
                  2'h3: begin
                     d.slink = rd_data;
                     if (rd_data == `DCS_NULL_PTR) d.nlf = 1'b1; // [RULE13]
                  end
               endcase
               d.widx = q.widx + 2'h1;
               if (q.widx == `DCS_DESC_LAST) d.st = dcs_pkg::st_load;
            end
         end
         dcs_pkg::st_load: begin
            // fetched set becomes the primary set, pointer included [RULE8]
            d.psrc  = q.ssrc;
            d.pdst  = q.sdst;
            d.plen  = q.slen;
            d.plink = q.slink;
            d.cnt   = `DCS_RST_WORD;
            ld = 1'b1;
            d.st = dcs_pkg::st_run;
         end
         dcs_pkg::st_run: begin
            if (beat_hs) d.cnt = q.cnt + wsb;
            if (!(q.cnt < q.plen)) d.st = dcs_pkg::st_term; // [RULE23]
         end
         dcs_pkg::st_term: begin
            // chained channels may report only the final count [RULE12]
            if (!q.chain || !q.csel || final_tc) begin
               d.tcf = 1'b1;
               d.tc_pulse = 1'b1;
            end
            if (q.chain) begin
               if (final_tc) begin
                  d.sval = 1'b0;           // chain done [RULE14]
                  d.run  = 1'b0;           // [RULE9]
                  d.st   = dcs_pkg::st_idle;
               end else begin
                  d.fptr = q.plink;        // next descriptor [RULE9]
                  d.widx = 2'h0;
                  d.st   = dcs_pkg::st_fetch;
               end
            end else if (q.sval) begin
               // reload with the count, no gap in between [RULE24]
               d.psrc = q.ssrc;
               d.pdst = q.sdst;
               d.plen = q.slen;
               d.cnt  = `DCS_RST_WORD;
               d.sval = 1'b0;              // secondary now empty [RULE3]
               d.run  = 1'b1;              // [RULE2]
               ld = 1'b1;
               d.st = dcs_pkg::st_run;
            end else begin
               d.run = 1'b0;               // stays off until rewritten [RULE1] [RULE5]
               d.st  = dcs_pkg::st_idle;
            end
         end
         default: d.st = dcs_pkg::st_idle; // unused codes recover
      endcase
      // software writes in the data phase; a run or valid set beats hardware
      if (q.aw_v && q.aw_w) begin
         unique case (q.aw_a)
            `DCS_OFF_CTRL: begin
               d.run   = hwdata[`DCS_B_RUN];
               d.sval  = hwdata[`DCS_B_SVAL];
               d.chain = hwdata[`DCS_B_CHAIN];
               d.csel  = hwdata[`DCS_B_CSEL];
               d.shold = hwdata[`DCS_B_SHOLD];
               d.dhold = hwdata[`DCS_B_DHOLD];
               d.ssz   = hwdata[`DCS_F_SSZ_LO +: 2];
               d.dsz   = hwdata[`DCS_F_DSZ_LO +: 2];
               d.sson  = hwdata[`DCS_B_SSTR];         // [RULE15]
               d.dson  = hwdata[`DCS_B_DSTR];         // [RULE15]
               d.smul  = hwdata[`DCS_F_MUL_LO +: 3];
               d.scnt  = hwdata[`DCS_F_CNT_LO +: 3];
               d.burst = hwdata[`DCS_B_BURST];        // [RULE20]
               d.lowp  = hwdata[`DCS_B_LOWP];         // [RULE20]
            end
            `DCS_OFF_PSRC:  d.psrc  = hwdata;
            `DCS_OFF_PDST:  d.pdst  = hwdata;
            `DCS_OFF_PLEN:  d.plen  = hwdata;
            `DCS_OFF_PLINK: d.plink = hwdata;
            `DCS_OFF_SSRC:  d.ssrc  = hwdata;
            `DCS_OFF_SDST:  d.sdst  = hwdata;
            `DCS_OFF_SLEN:  d.slen  = hwdata;
            `DCS_OFF_SLINK: d.slink = hwdata;
            `DCS_OFF_MASK:  d.nlm   = hwdata[`DCS_B_NULL];
            default: ;      // status handled above, others read-only or unmapped
         endcase
      end
      // address phase capture and registered read data
      d.aw_v = a_phase;
      d.aw_w = hwrite;
      d.aw_a = haddr[7:0];
      if (a_phase && !hwrite) d.hrdata = rd_mux(q, haddr[7:0]);
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) q <= '0;
      else          q <= d;
   end

   ////////////////////////////////////////////////////////////////////////
   // source and destination walkers share one structure
   for (genvar g = 0; g < 2; g++) begin : g_walk
      dcs_stride u_walk (
         .hclk      (hclk),
         .hresetn   (hresetn),
         .load      (ld),
         .base      (g == 0 ? ld_src : ld_dst),
         .step      (beat_hs),
         .hold      (g == 0 ? q.shold : q.dhold),
         .stride_on (g == 0 ? q.sson : q.dson),     // [RULE15]
         .size      (g == 0 ? q.ssz : q.dsz),
         .mult      (q.smul),
         .cnt       (q.scnt),
         .addr      (addr_w[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_term_plain;
      q.st == dcs_pkg::st_term && !q.chain && !ctrl_wr;
   endsequence
   sequence s_last_word;
      q.st == dcs_pkg::st_fetch && rd_ack && q.widx == `DCS_DESC_LAST;
   endsequence

   AST_TC_STOPS: assert property (s_term_plain and !q.sval |=> !q.run ##1 !q.run) // [RULE1]
      else $error("run not cleared at count");
   AST_DBUF_RERUN: assert property (s_term_plain and q.sval // [RULE2]
      |=> q.run && q.st == dcs_pkg::st_run && q.psrc == $past(q.ssrc)
          && q.plen == $past(q.slen)) else $error("reload failed");
   AST_SVAL_CLEAR: assert property (s_term_plain and q.sval |=> !q.sval) // [RULE3]
      else $error("secondary valid kept");
   AST_EMPTY_STOP: assert property (s_term_plain and !q.sval // [RULE5]
      |=> q.st == dcs_pkg::st_idle) else $error("empty secondary kept running");
   AST_CHAIN_START: assert property (q.st == dcs_pkg::st_idle && q.run && q.chain // [RULE8]
      && !final_tc |=> q.st == dcs_pkg::st_fetch && rd_addr == $past(q.plink))
      else $error("chain start wrong");
   AST_DESC_LOAD: assert property (s_last_word |=> q.st == dcs_pkg::st_load // [RULE11]
      ##1 q.st == dcs_pkg::st_run && q.plink == $past(q.slink))
      else $error("descriptor not copied");
   AST_NULL_END: assert property (q.st == dcs_pkg::st_term && q.chain && final_tc // [RULE9]
      && !ctrl_wr |=> !q.run && !q.sval && q.st == dcs_pkg::st_idle)
      else $error("null link did not end chain");
   AST_NULL_FLAG: assert property (s_last_word and rd_data == `DCS_NULL_PTR // [RULE13]
      |=> q.nlf) else $error("null-link flag missed");
   AST_TC_SELECT: assert property (q.st == dcs_pkg::st_term && q.chain && q.csel // [RULE12]
      && !final_tc |=> !tc_event) else $error("mid-chain count reported");
   AST_COUNT_END: assert property (q.st == dcs_pkg::st_run && !(q.cnt < q.plen) // [RULE23]
      |-> !beat_valid ##1 q.st == dcs_pkg::st_term ##1 tc_event || q.chain)
      else $error("terminal count missed");
endmodule
`default_nettype wire

// [src/dcs_stride.sv]
// Purpose: one address walker: plain increment, hold, or stride sets
// Assumes: step pulses only while the channel runs
// Notes:   step size is (multiplier+1) words; a set has count+1 addresses
`include "dcs_cfg.svh"
`default_nettype none
module dcs_stride (
   input  wire logic        hclk,      // system clock
   input  wire logic        hresetn,   // async reset, low
   input  wire logic        load,      // restart at base
   input  wire logic [31:0] base,      // channel start address
   input  wire logic        step,      // one beat moved
   input  wire logic        hold,      // address does not move
   input  wire logic        stride_on, // stride mode
   input  wire logic [1:0]  size,      // word size code
   input  wire logic [2:0]  mult,      // stride multiplier field
   input  wire logic [2:0]  cnt,       // stride step count field
   output logic      [31:0] addr       // current address
);
   dcs_pkg::dcs_strd_s q, d;   // state and next state
   logic [31:0]        wsb;    // word size in bytes
   logic [31:0]        stepb;  // stride step in bytes

   // word and stride sizes
   assign wsb   = `DCS_ONE32 << size;
   assign stepb = ({29'h0, mult} + `DCS_ONE32) * wsb; // [RULE17]
   assign addr  = q.cur;

   ////////////////////////////////////////////////////////////////////////
   // next address
   always_comb begin
      d = q;
      if (load) begin
         d.set = base;                   // first set at channel address [RULE19]
         d.cur = base;
         d.idx = 3'h0;
      end else if (step && !hold) begin
         if (stride_on) begin
            if (q.idx == cnt) begin      // set done after cnt+1 steps [RULE18]
               d.set = q.set + wsb;      // next set one word on [RULE19]
               d.cur = q.set + wsb;
               d.idx = 3'h0;
            end else begin
               d.cur = q.cur + stepb;    // [RULE17]
               d.idx = q.idx + 3'h1;
            end
         end else begin
            d.cur = q.cur + wsb;         // default increment
         end
      end
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) q <= '0;
      else          q <= d;
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_STRIDE_STEP: assert property (step && !hold && stride_on && !load // [RULE17]
      && q.idx != cnt |=> q.cur == $past(q.cur) + $past(stepb))
      else $error("stride step wrong");
   AST_STRIDE_WRAP: assert property (step && !hold && stride_on && !load // [RULE18]
      && q.idx == cnt |=> q.cur == $past(q.set) + $past(wsb) && q.idx == 3'h0)
      else $error("stride set restart wrong");
endmodule
`default_nettype wire

// [testbench/dcs_mem_model.sv]
// Purpose: far side of the sequencer: descriptor memory and beat mover
// Assumes: rd_ack is a one-cycle pulse
// Notes:   mem is filled by the bench; words from 0x1000 upward
`default_nettype none
module dcs_mem_model (
   input  wire logic        hclk,      // system clock
   input  wire logic        hresetn,   // async reset, low
   input  wire logic        rd_req,    // word wanted
   input  wire logic [31:0] rd_addr,   // word address
   output logic             rd_ack,    // word valid pulse
   output logic      [31:0] rd_data,   // word
   output logic             beat_ready // mover accepts
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] mem [0:15]; // descriptor words
   ////////////////////////////////////////////////////////////////////
   // random waits: reads and beats both prompt and slow
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ack     <= 1'b0;
         rd_data    <= 32'h0000_0000;
         beat_ready <= 1'b0;
      end else begin
         beat_ready <= ($urandom % 4) != 0;
         if (rd_req && !rd_ack && ($urandom % 2) == 0) begin
            rd_ack  <= 1'b1;
            rd_data <= mem[rd_addr[5:2]];
         end else begin
            rd_ack  <= 1'b0;
            rd_data <= ~rd_data; // no stale word between answers
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/test_dcs_seq.sv]
// Purpose: self-checking bench of the channel sequencer
// Assumes: zero-wait slave; hready fed from hreadyout
// Notes:   beats are noted in exp_q and checked by a monitor
`include "dcs_cfg.svh"
`default_nettype none
module test_dcs_seq;
   timeunit 1ns;
   timeprecision 1ns;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_req, rd_ack;
   logic beat_valid, beat_ready, tc_event, null_link_summary;
   logic [31:0] haddr, hwdata, hrdata, rd_addr, rd_data, v, sb;
   logic [1:0] htrans;
   logic [2:0] hsize;
   dcs_pkg::dcs_beat_s beat;
   dcs_pkg::dcs_beat_s exp_q[$]; // beats still to come
   int error_cnt, n_compared, tc_n, tcx;
   dcs_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data),
      .beat_valid(beat_valid), .beat(beat), .beat_ready(beat_ready),
      .tc_event(tc_event), .null_link_summary(null_link_summary));
   dcs_mem_model mem_i (.hclk(hclk), .hresetn(hresetn), .rd_req(rd_req),
      .rd_addr(rd_addr), .rd_ack(rd_ack), .rd_data(rd_data), .beat_ready(beat_ready));
   ////////////////////////////////////////////////////////////////////
   // clock, 20 ns period
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   task automatic chk(input logic [72:0] seen, input logic [72:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // one single AHB-Lite transfer, waits on hready in both phases
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge hclk); while (hready_lo());
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hready_lo());
      r = hrdata;
   endtask
   function automatic logic hready_lo();
      return hreadyout !== 1'b1;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask
   task automatic wait_tc(input int n);
      for (int k = 0; k < 2000 && tc_n < n; k++) @(posedge hclk);
      repeat (30) @(posedge hclk); // let a stray extra count show
   endtask
   function automatic logic [31:0] ctl(input logic r, s, c, cs, ds, bl,
                                       input logic [2:0] m, n);
      ctl = 32'h0000_0000; // holds stay clear
      ctl[`DCS_B_RUN] = r;
      ctl[`DCS_B_SVAL] = s;
      ctl[`DCS_B_CHAIN] = c;
      ctl[`DCS_B_CSEL] = cs;
      ctl[`DCS_B_DSTR] = ds;
      ctl[`DCS_B_BURST] = bl;
      ctl[`DCS_B_LOWP] = bl; // burst and low group kept equal
      ctl[`DCS_F_SSZ_LO +: 2] = 2'h2;
      ctl[`DCS_F_DSZ_LO +: 2] = 2'h2;
      ctl[`DCS_F_MUL_LO +: 3] = m;
      ctl[`DCS_F_CNT_LO +: 3] = n;
   endfunction
   function automatic dcs_pkg::dcs_beat_s bt(input logic [31:0] s, d, input logic b);
      return '{src: s, dst: d, ssz: 2'h2, dsz: 2'h2, burst: b};
   endfunction
   ////////////////////////////////////////////////////////////////////
   // monitor: each accepted beat against the oldest note
   always @(posedge hclk) begin
      if (tc_event === 1'b1) tc_n++;
      if (beat_valid === 1'b1 && beat_ready === 1'b1) begin
         if (exp_q.size() == 0) chk(beat, 73'h0_dead);
         else chk(beat, exp_q.pop_front());
      end
   end
   // watchdog, far beyond the few hundred cycles of the run
   initial begin
      repeat (20000) @(posedge hclk);
      error_cnt++;
      results();
   end
   initial begin
      {hsel, hwrite, htrans, hsize, haddr, hwdata, hresetn} = '0;
      sb = $urandom(32'hbd53);
      foreach (mem_i.mem[i]) mem_i.mem[i] = 32'h0000_0000;
      mem_i.mem[0] = 32'h0000_0300;
      mem_i.mem[1] = 32'h0000_0400;
      mem_i.mem[2] = 32'h0000_0008;
      mem_i.mem[3] = 32'h0000_1010;
      mem_i.mem[4] = 32'h0000_0500;
      mem_i.mem[5] = 32'h0000_0600;
      mem_i.mem[6] = 32'h0000_0004;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, `DCS_OFF_COUNT, 32'h0, v);
      chk(v, 0);
      $display("test reset done");
      // stride on destination, random aligned source
      sb = $urandom & 32'h0000_fff0;
      wr(`DCS_OFF_PSRC, sb);
      wr(`DCS_OFF_PDST, 32'h0000_0100);
      wr(`DCS_OFF_PLEN, 32'h0000_0030);
      for (int i = 0; i < 12; i++) exp_q.push_back(bt(sb + 4 * i,
         32'h100 + (i % 3) * 16 + (i / 3) * 4, 1'b0));
      wr(`DCS_OFF_CTRL, ctl(1, 0, 0, 0, 1, 0, 3'h3, 3'h2));
      wait_tc(1);
      chk(tc_n, 1);
      bus(1'b0, `DCS_OFF_CTRL, 32'h0, v);
      chk(v, ctl(0, 0, 0, 0, 1, 0, 3'h3, 3'h2));
      bus(1'b0, `DCS_OFF_COUNT, 32'h0, v);
      chk(v, 32'h30);
      wr(`DCS_OFF_STAT, 32'h1);
      $display("test stride done");
      // double buffer with burst passed on each beat
      wr(`DCS_OFF_PSRC, 32'h200); // stopped, secondary empty
      wr(`DCS_OFF_PDST, 32'h100);
      wr(`DCS_OFF_PLEN, 32'h4);
      wr(`DCS_OFF_SSRC, 32'h240);
      wr(`DCS_OFF_SDST, 32'h140);
      wr(`DCS_OFF_SLEN, 32'h8);
      exp_q.push_back(bt(32'h200, 32'h100, 1'b1));
      exp_q.push_back(bt(32'h240, 32'h140, 1'b1));
      exp_q.push_back(bt(32'h244, 32'h144, 1'b1));
      wr(`DCS_OFF_CTRL, ctl(1, 1, 0, 0, 0, 1, 3'h0, 3'h0));
      wait_tc(3);
      chk(tc_n, 3);
      bus(1'b0, `DCS_OFF_CTRL, 32'h0, v);
      chk(v, ctl(0, 0, 0, 0, 0, 1, 3'h0, 3'h0));
      bus(1'b0, `DCS_OFF_PSRC, 32'h0, v);
      chk(v, 32'h240);
      $display("test double buffer done");
      // chain of two descriptors, interrupt every count then final only
      for (int cs = 0; cs < 2; cs++) begin
         wr(`DCS_OFF_PSRC, $urandom); // ignored while chaining
         wr(`DCS_OFF_PLINK, 32'h0000_1000);
         wr(`DCS_OFF_MASK, cs << 1);
         tcx = tc_n + 2 - cs;
         exp_q.push_back(bt(32'h300, 32'h400, 1'b0));
         exp_q.push_back(bt(32'h304, 32'h404, 1'b0));
         exp_q.push_back(bt(32'h500, 32'h600, 1'b0));
         wr(`DCS_OFF_CTRL, ctl(1, 1, 1, cs[0], 0, 0, 3'h0, 3'h0));
         wait_tc(tcx);
         chk(tc_n, tcx);
         chk(null_link_summary, !cs[0]);
         bus(1'b0, `DCS_OFF_CTRL, 32'h0, v);
         chk(v, ctl(0, 0, 1, cs[0], 0, 0, 3'h0, 3'h0));
         wr(`DCS_OFF_CTRL, 32'h0); // chain off before next chain
         wr(`DCS_OFF_STAT, 32'h3);
         @(posedge hclk);
         chk(null_link_summary, 0);
         $display("test chain %0d done", cs);
      end
      chk(exp_q.size(), 0);
      results();
   end
endmodule
`default_nettype wire
